// File: src/dpr_delay.sv
`timescale 1ns/10ps
module dpr_delay
    import dpr_pkg::*;
#(
    parameter int CNT_W = DLY_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic src_good,
    input wire logic [CNT_W-1:0] delay_ticks,
    output logic delayed_good
);

    generate
        if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
            $error("dpr_delay: CNT_W out of range");
        end
    endgenerate

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic out;
    } dpr_dstate_t;

    dpr_dstate_t s_reg;
    dpr_dstate_t s_next;

    always_comb begin
        s_next = s_reg;
        if (!src_good) begin
            // Drop at once and start over on the next rise
            s_next.cnt = '0;
            s_next.out = 1'b0;
        end else if (!s_reg.out) begin
            if (s_reg.cnt >= delay_ticks) begin
                s_next.out = 1'b1;
            end else if (tick) begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign delayed_good = s_reg.out;

endmodule : dpr_delay

// File: src/dpr_pkg.sv
package dpr_pkg;

    localparam int ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DISCH2 = 8'h3d;
    localparam logic [7:0] IDX_DISCH3 = 8'h3e;
    localparam logic [7:0] IDX_DISCH4 = 8'h3f;
    localparam logic [7:0] IDX_PGDLY = 8'h40;
    localparam logic [7:0] IDX_SLEEP = 8'h41;
    localparam logic [7:0] IDX_LOCK = 8'h42;

    localparam logic [7:0] RST_DISCH2 = 8'h00;
    localparam logic [7:0] RST_DISCH3 = 8'h00;
    localparam logic [7:0] RST_DISCH4 = 8'h00;
    localparam logic [7:0] RST_PGDLY = 8'h5f;
    localparam logic [7:0] RST_SLEEP = 8'h00;
    localparam logic [7:0] RST_LOCK = 8'h00;

    // Writable bits; the rest are reserved and read as zero
    localparam logic [7:0] WMASK_DISCH4 = 8'h3f;
    localparam logic [7:0] WMASK_PGDLY = 8'h7f;
    localparam logic [7:0] WMASK_LOCK = 8'h01;

    // Selector field positions: two bits each, three bits for SYSOK, single bits for sleep and lock
    localparam int MAIN5V_LSB = 6;
    localparam int DEEP3V3_LSB = 4;
    localparam int CHIP3V3_LSB = 2;
    localparam int AON1V8_LSB = 0;
    localparam int MID_LSB = 6;
    localparam int R1V2_LSB = 4;
    localparam int AON1V0_LSB = 2;
    localparam int AON0V85_LSB = 0;
    localparam int SW3V3_LSB = 4;
    localparam int SW1V8_LSB = 2;
    localparam int SW1V0_LSB = 0;
    localparam int RESUME_LSB = 5;
    localparam int CHIPOK_LSB = 3;
    localparam int SYSOK_LSB = 0;
    localparam int SLEEP_S4_BIT = 1;
    localparam int DEEP_S4_BIT = 0;
    localparam int LOCK_BIT = 0;

    // Resistance in ohms; zero means no discharge path
    localparam int OHM_W = 10;
    typedef logic [3:0][OHM_W-1:0] dpr_ohm_tab_t;
    localparam dpr_ohm_tab_t OHM_STD = {10'h1f4, 10'h0c8, 10'h064, 10'h000};
    localparam dpr_ohm_tab_t OHM_AON1V8 = {10'h1f4, 10'h0c8, 10'h064, 10'h35c};
    localparam dpr_ohm_tab_t OHM_MID = {10'h226, 10'h0e1, 10'h07d, 10'h000};
    localparam dpr_ohm_tab_t OHM_LOW = {10'h23f, 10'h0fa, 10'h096, 10'h000};

    // Slow tick timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 30500;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_CNT_W = $clog2(TICK_CYCLES);

    localparam int DLY_W = 12;
    typedef logic [DLY_W-1:0] dpr_dly_t;
    localparam dpr_dly_t DLY_82 = 12'h052;
    localparam dpr_dly_t DLY_164 = 12'h0a4;
    localparam dpr_dly_t DLY_328 = 12'h148;
    localparam dpr_dly_t DLY_360 = 12'h168;
    localparam dpr_dly_t DLY_492 = 12'h1ec;
    localparam dpr_dly_t DLY_656 = 12'h290;
    localparam dpr_dly_t DLY_721 = 12'h2d1;
    localparam dpr_dly_t DLY_1640 = 12'h668;
    localparam dpr_dly_t DLY_2460 = 12'h99c;
    localparam dpr_dly_t DLY_3280 = 12'hcd0;

    typedef logic [3:0][DLY_W-1:0] dpr_dly_tab4_t;
    typedef logic [7:0][DLY_W-1:0] dpr_dly_tab8_t;
    localparam dpr_dly_tab4_t DLY_RESUME = {DLY_721, DLY_360, DLY_164, 12'h000};
    // Code 01 is undefined; it is served as the shortest delay
    localparam dpr_dly_tab4_t DLY_CHIPOK = {DLY_656, DLY_328, DLY_82, DLY_82};
    localparam dpr_dly_tab8_t DLY_SYSOK = {DLY_3280, DLY_2460, DLY_1640, DLY_656,
                                           DLY_492, DLY_328, DLY_164, DLY_82};

endpackage : dpr_pkg

// File: src/dpr_regs.sv
`timescale 1ns/10ps
module dpr_regs
    import dpr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic resume_power_good,
    input wire logic all_rails_good,
    output logic resume_reset_good,
    output logic chipset_power_ok,
    output logic system_power_ok,
    output logic [OHM_W-1:0] main5v_discharge_ohm,
    output logic [OHM_W-1:0] deepsleep3v3_discharge_ohm,
    output logic [OHM_W-1:0] chipset3v3_discharge_ohm,
    output logic [OHM_W-1:0] always1v8_discharge_ohm,
    output logic [OHM_W-1:0] mid_rail_discharge_ohm,
    output logic [OHM_W-1:0] rail1v2_discharge_ohm,
    output logic [OHM_W-1:0] always1v0_discharge_ohm,
    output logic [OHM_W-1:0] always0v85_discharge_ohm,
    output logic [OHM_W-1:0] switched3v3_discharge_ohm,
    output logic [OHM_W-1:0] switched1v8_discharge_ohm,
    output logic [OHM_W-1:0] switched1v0_discharge_ohm,
    output logic controller_sleep_s4_en,
    output logic controller_deep_s4_en,
    output logic control_write_lock
);

    generate
        if (ADDR_W < 11) begin : g_bad_addr
            $error("dpr_regs: ADDR_W too small for the register map");
        end
    endgenerate

    localparam int RAILS = 11;

    typedef struct packed {
        logic [7:0] disch2;
        logic [7:0] disch3;
        logic [7:0] disch4;
        logic [7:0] pgdly;
        logic [7:0] sleep;
        logic [7:0] lock;
        logic ready;
        logic [31:0] rdata;
        logic slverr;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic tick;
        logic [RAILS-1:0][OHM_W-1:0] ohm;
        dpr_dly_t dly_resume;
        dpr_dly_t dly_chipok;
        dpr_dly_t dly_sysok;
    } dpr_state_t;

    dpr_state_t s_reg;
    dpr_state_t s_next;

    logic [7:0] idx;
    logic aligned;
    logic hit;
    logic [7:0] rd_byte;
    logic wr_en;
    logic [7:0] wbyte;

    function automatic logic [7:0] dpr_merge(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask
    );
        dpr_merge = (old_val & ~mask) | (new_val & mask);
    endfunction : dpr_merge

    // Word index of the access; low two address bits must be zero
    always_comb begin
        idx = paddr[9:2];
        aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
        hit = 1'b0;
        rd_byte = 8'h00;
        if (aligned) begin
            unique case (idx)
                IDX_DISCH2: begin
                    hit = 1'b1;
                    rd_byte = s_reg.disch2;
                end
                IDX_DISCH3: begin
                    hit = 1'b1;
                    rd_byte = s_reg.disch3;
                end
                IDX_DISCH4: begin
                    hit = 1'b1;
                    rd_byte = s_reg.disch4 & WMASK_DISCH4;
                end
                IDX_PGDLY: begin
                    hit = 1'b1;
                    rd_byte = s_reg.pgdly & WMASK_PGDLY;
                end
                IDX_SLEEP: begin
                    hit = 1'b1;
                    rd_byte = s_reg.sleep;
                end
                IDX_LOCK: begin
                    hit = 1'b1;
                    rd_byte = s_reg.lock & WMASK_LOCK;
                end
                default: begin
                    hit = 1'b0;
                    rd_byte = 8'h00;
                end
            endcase
        end
    end

    // A write lands only on the access edge that also shows pready high
    assign wr_en = psel && penable && pwrite && s_reg.ready && !s_reg.slverr && pstrb[0];
    assign wbyte = pwdata[7:0];

    always_comb begin
        s_next = s_reg;

        // Slow tick derived from the bus clock
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
            s_next.tick_cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
        end

        // Answer one cycle after setup: pready high in the first access cycle
        if (psel && !penable) begin
            s_next.ready = 1'b1;
            s_next.slverr = !hit;
            s_next.rdata = hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end else begin
            s_next.ready = 1'b0;
            s_next.slverr = 1'b0;
        end

        if (wr_en) begin
            unique case (idx)
                IDX_DISCH2: s_next.disch2 = wbyte;
                IDX_DISCH3: s_next.disch3 = wbyte;
                IDX_DISCH4: s_next.disch4 = dpr_merge(s_reg.disch4, wbyte, WMASK_DISCH4);
                IDX_PGDLY: s_next.pgdly = dpr_merge(s_reg.pgdly, wbyte, WMASK_PGDLY);
                IDX_SLEEP: s_next.sleep = wbyte;
                IDX_LOCK: s_next.lock = dpr_merge(s_reg.lock, wbyte, WMASK_LOCK);
                default: s_next.sleep = s_reg.sleep;
            endcase
        end

        // Discharge selector decode to ohms
        s_next.ohm[10] = OHM_STD[s_reg.disch2[MAIN5V_LSB +: 2]];
        s_next.ohm[9] = OHM_STD[s_reg.disch2[DEEP3V3_LSB +: 2]];
        s_next.ohm[8] = OHM_STD[s_reg.disch2[CHIP3V3_LSB +: 2]];
        s_next.ohm[7] = OHM_AON1V8[s_reg.disch2[AON1V8_LSB +: 2]];
        s_next.ohm[6] = OHM_STD[s_reg.disch3[MID_LSB +: 2]];
        s_next.ohm[5] = OHM_MID[s_reg.disch3[R1V2_LSB +: 2]];
        s_next.ohm[4] = OHM_MID[s_reg.disch3[AON1V0_LSB +: 2]];
        s_next.ohm[3] = OHM_LOW[s_reg.disch3[AON0V85_LSB +: 2]];
        s_next.ohm[2] = OHM_STD[s_reg.disch4[SW3V3_LSB +: 2]];
        s_next.ohm[1] = OHM_STD[s_reg.disch4[SW1V8_LSB +: 2]];
        s_next.ohm[0] = OHM_STD[s_reg.disch4[SW1V0_LSB +: 2]];

        // Power-good delay selection in slow ticks
        s_next.dly_resume = DLY_RESUME[s_reg.pgdly[RESUME_LSB +: 2]];
        s_next.dly_chipok = DLY_CHIPOK[s_reg.pgdly[CHIPOK_LSB +: 2]];
        s_next.dly_sysok = DLY_SYSOK[s_reg.pgdly[SYSOK_LSB +: 3]];
    end

    // Decoded values reset to what the reset register contents decode to
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg.disch2 <= RST_DISCH2;
            s_reg.disch3 <= RST_DISCH3;
            s_reg.disch4 <= RST_DISCH4;
            s_reg.pgdly <= RST_PGDLY;
            s_reg.sleep <= RST_SLEEP;
            s_reg.lock <= RST_LOCK;
            s_reg.ready <= 1'b0;
            s_reg.rdata <= 32'h0000_0000;
            s_reg.slverr <= 1'b0;
            s_reg.tick_cnt <= '0;
            s_reg.tick <= 1'b0;
            s_reg.ohm <= {OHM_STD[0], OHM_STD[0], OHM_STD[0], OHM_AON1V8[0],
                          OHM_STD[0], OHM_MID[0], OHM_MID[0], OHM_LOW[0],
                          OHM_STD[0], OHM_STD[0], OHM_STD[0]};
            s_reg.dly_resume <= DLY_RESUME[RST_PGDLY[RESUME_LSB +: 2]];
            s_reg.dly_chipok <= DLY_CHIPOK[RST_PGDLY[CHIPOK_LSB +: 2]];
            s_reg.dly_sysok <= DLY_SYSOK[RST_PGDLY[SYSOK_LSB +: 3]];
        end else begin
            s_reg <= s_next;
        end
    end

    dpr_delay #(
        .CNT_W(DLY_W)
    ) u_resume_dly (
        .pclk(pclk),
        .presetn(presetn),
        .tick(s_reg.tick),
        .src_good(resume_power_good),
        .delay_ticks(s_reg.dly_resume),
        .delayed_good(resume_reset_good)
    );

    dpr_delay #(
        .CNT_W(DLY_W)
    ) u_chipok_dly (
        .pclk(pclk),
        .presetn(presetn),
        .tick(s_reg.tick),
        .src_good(all_rails_good),
        .delay_ticks(s_reg.dly_chipok),
        .delayed_good(chipset_power_ok)
    );

    dpr_delay #(
        .CNT_W(DLY_W)
    ) u_sysok_dly (
        .pclk(pclk),
        .presetn(presetn),
        .tick(s_reg.tick),
        .src_good(all_rails_good),
        .delay_ticks(s_reg.dly_sysok),
        .delayed_good(system_power_ok)
    );

    assign pready = s_reg.ready;
    assign prdata = s_reg.rdata;
    assign pslverr = s_reg.slverr;

    assign main5v_discharge_ohm = s_reg.ohm[10];
    assign deepsleep3v3_discharge_ohm = s_reg.ohm[9];
    assign chipset3v3_discharge_ohm = s_reg.ohm[8];
    assign always1v8_discharge_ohm = s_reg.ohm[7];
    assign mid_rail_discharge_ohm = s_reg.ohm[6];
    assign rail1v2_discharge_ohm = s_reg.ohm[5];
    assign always1v0_discharge_ohm = s_reg.ohm[4];
    assign always0v85_discharge_ohm = s_reg.ohm[3];
    assign switched3v3_discharge_ohm = s_reg.ohm[2];
    assign switched1v8_discharge_ohm = s_reg.ohm[1];
    assign switched1v0_discharge_ohm = s_reg.ohm[0];

    assign controller_sleep_s4_en = s_reg.sleep[SLEEP_S4_BIT];
    assign controller_deep_s4_en = s_reg.sleep[DEEP_S4_BIT];
    // Regulator control registers live elsewhere and refuse writes while this is high
    assign control_write_lock = s_reg.lock[LOCK_BIT];

endmodule : dpr_regs

// File: tb/dpr_regs_assertions.sv
`timescale 1ns/10ps
module dpr_regs_assertions
    import dpr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic all_rails_good,
    input wire logic resume_power_good,
    input wire logic resume_reset_good,
    input wire logic chipset_power_ok,
    input wire logic system_power_ok,
    input wire logic [OHM_W-1:0] main5v_discharge_ohm,
    input wire logic [OHM_W-1:0] always1v8_discharge_ohm,
    input wire logic [OHM_W-1:0] always0v85_discharge_ohm,
    input wire logic control_write_lock
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [ADDR_W-1:0] a);
        psel && penable && pready && pwrite && pstrb[0] && paddr == a;
    endsequence

    // Decoded outputs land one cycle after the storing edge
    a_lock_store: assert property (s_wr(12'h108) |=> ##1 control_write_lock == $past(pwdata[0], 2))
        else $error("lock bit not stored");
    a_main5v_dec: assert property (s_wr(12'h0f4) |=> ##1 main5v_discharge_ohm == OHM_STD[$past(pwdata[7:6], 2)])
        else $error("main 5v decode wrong");
    a_aon1v8_dec: assert property (s_wr(12'h0f4) |=> ##1 always1v8_discharge_ohm == OHM_AON1V8[$past(pwdata[1:0], 2)])
        else $error("1v8 decode wrong");
    a_aon0v85_dec: assert property (s_wr(12'h0f8) |=> ##1 always0v85_discharge_ohm == OHM_LOW[$past(pwdata[1:0], 2)])
        else $error("0v85 decode wrong");
    a_sys_drop: assert property (!all_rails_good [*2] |=> !system_power_ok)
        else $error("system ok not dropped");
    a_chip_drop: assert property (!all_rails_good [*2] |=> !chipset_power_ok)
        else $error("chipset ok not dropped");
    a_resume_drop: assert property (!resume_power_good [*2] |=> !resume_reset_good)
        else $error("resume good not dropped");
    a_sys_wait: assert property ($rose(all_rails_good) |=> !system_power_ok [*8])
        else $error("system ok too early");
    a_chip_wait: assert property ($rose(all_rails_good) |=> !chipset_power_ok [*8])
        else $error("chipset ok too early");
endmodule : dpr_regs_assertions

bind dpr_regs dpr_regs_assertions i_chk (.*);

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import dpr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic rpg, arg, rrg, cpo, spo, s4, ds4, lock;
    logic [OHM_W-1:0] o [11];
    int miscompares, n_compared, seed;
    logic [32:0] q[$];
    logic [7:0] wv [6];
    logic [11:0] ra [6] = '{12'h0f4, 12'h0f8, 12'h0fc, 12'h100, 12'h104, 12'h108};
    logic [7:0] rm [6] = '{8'hff, 8'hff, 8'h3f, 8'h7f, 8'hff, 8'h01};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h5f, 8'h00, 8'h00};
    int ohm_std [4] = '{0, 100, 200, 500};
    int aon [4] = '{860, 100, 200, 500};
    int mid [4] = '{0, 125, 225, 550};
    int low [4] = '{0, 150, 250, 575};

    dpr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .resume_power_good(rpg), .all_rails_good(arg),
        .resume_reset_good(rrg), .chipset_power_ok(cpo), .system_power_ok(spo),
        .main5v_discharge_ohm(o[0]), .deepsleep3v3_discharge_ohm(o[1]),
        .chipset3v3_discharge_ohm(o[2]), .always1v8_discharge_ohm(o[3]),
        .mid_rail_discharge_ohm(o[4]), .rail1v2_discharge_ohm(o[5]),
        .always1v0_discharge_ohm(o[6]), .always0v85_discharge_ohm(o[7]),
        .switched3v3_discharge_ohm(o[8]), .switched1v8_discharge_ohm(o[9]),
        .switched1v0_discharge_ohm(o[10]), .controller_sleep_s4_en(s4),
        .controller_deep_s4_en(ds4), .control_write_lock(lock));

    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] s, input logic [32:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : cyc

    // Request held until the edge that samples pready; expected read values go to the queue
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s, input logic [32:0] e);
        int n;
        n = 0;
        if (!w)
            q.push_back(e);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        // Sampled at the rising edge itself: the write lands on this same edge
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            miscompares++;
        psel <= 0;
        penable <= 0;
    endtask : apb

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, q.pop_front());
    end

    initial begin
        repeat (90000) @(posedge pclk);
        miscompares++;
        stop_test();
    end

    initial begin
        seed = 32'hdd32_06fb;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        pstrb = 0;
        rpg = 0;
        arg = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        // Reserved bits are written as ones to prove they are dropped
        for (int i = 0; i < 6; i++) begin
            apb(0, ra[i], 8'h00, 4'hf, {25'h0, rv[i]});
            wv[i] = 8'($random(seed));
            apb(1, ra[i], wv[i] | ~rm[i], 4'hf, 33'h0);
            apb(0, ra[i], 8'h00, 4'hf, {25'h0, wv[i] & rm[i]});
            apb(1, ra[i], ~wv[i], 4'he, 33'h0);
            apb(0, ra[i], 8'h00, 4'hf, {25'h0, wv[i] & rm[i]});
        end
        cyc(2);
        check(33'(lock), 33'(wv[5][0]));
        check(33'({s4, ds4}), 33'(wv[4][1:0]));
        apb(1, 12'h108, 8'h01, 4'hf, 33'h0);
        apb(0, 12'h108, 8'h00, 4'hf, 33'h1);
        check(33'(lock), 33'h1);
        apb(0, 12'h000, 8'h00, 4'hf, {1'b1, 32'h0});
        apb(0, 12'h0f5, 8'h00, 4'hf, {1'b1, 32'h0});
        for (int c = 0; c < 4; c++) begin
            apb(1, 12'h0f4, {4{c[1:0]}}, 4'hf, 33'h0);
            apb(1, 12'h0f8, {4{c[1:0]}}, 4'hf, 33'h0);
            apb(1, 12'h0fc, {4{c[1:0]}}, 4'hf, 33'h0);
            cyc(3);
            check(33'(o[0]), 33'(ohm_std[c]));
            check(33'(o[1]), 33'(ohm_std[c]));
            check(33'(o[2]), 33'(ohm_std[c]));
            check(33'(o[3]), 33'(aon[c]));
            check(33'(o[4]), 33'(ohm_std[c]));
            check(33'(o[5]), 33'(mid[c]));
            check(33'(o[6]), 33'(mid[c]));
            check(33'(o[7]), 33'(low[c]));
            check(33'(o[8]), 33'(ohm_std[c]));
            check(33'(o[9]), 33'(ohm_std[c]));
            check(33'(o[10]), 33'(ohm_std[c]));
        end
        // Shortest codes keep the run short; the tick phase is free running
        apb(1, 12'h100, 8'h00, 4'hf, 33'h0);
        @(posedge pclk);
        arg <= 1;
        rpg <= 1;
        cyc(3);
        check(33'(rrg), 33'h1);
        cyc(24697);
        check(33'({cpo, spo}), 33'h0);
        cyc(320);
        check(33'({cpo, spo}), 33'h3);
        @(posedge pclk);
        arg <= 0;
        rpg <= 0;
        cyc(3);
        check(33'({rrg, cpo, spo}), 33'h0);
        apb(1, 12'h100, 8'h20, 4'hf, 33'h0);
        @(posedge pclk);
        arg <= 1;
        rpg <= 1;
        cyc(24697);
        check(33'({rrg, spo}), 33'h0);
        cyc(320);
        check(33'({rrg, spo}), 33'h1);
        cyc(25010);
        check(33'(rrg), 33'h1);
        stop_test();
    end
endmodule : tb_top
